//--- pkg/led_pkg.sv
package led_pkg;
  // clock rate and flash timing
  localparam int CLK_HZ = 50_000_000;
  localparam int PHASE_MS = 200;
  localparam int GAP_MS = 1000;
  localparam int RAPID_MS = 50;
  localparam int PHASE_CYC = CLK_HZ / 1000 * PHASE_MS;
  localparam int RAPID_CYC = CLK_HZ / 1000 * RAPID_MS;
  localparam int GAP_STEPS = GAP_MS / PHASE_MS;
  // cycles the switch synchroniser needs before the start-up capture
  localparam logic [3:0] BOOT_WAIT_CYC = 4'h8;
  // error counter warning level
  localparam logic [7:0] WARN_LEVEL = 8'h60;
  // network management state codes from the protocol engine
  localparam logic [1:0] NMT_INIT = 2'h0;
  localparam logic [1:0] NMT_STOPPED = 2'h1;
  localparam logic [1:0] NMT_PREOP = 2'h2;
  localparam logic [1:0] NMT_OPER = 2'h3;
  // switch values
  localparam logic [7:0] NODE_ID_NONE = 8'h00;
  localparam logic [7:0] NODE_ID_GAP = 8'h80;
  localparam logic [3:0] BAUD_RUN_MAX = 4'h7;
  localparam logic [3:0] BAUD_INIT = 4'h9;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SWITCH = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // control bit positions
  localparam int CTRL_MODCLR_BIT = 0;
  localparam int CTRL_GUARDCLR_BIT = 1;
  // event bit positions in status and mask
  localparam int EV_MODULE = 0;
  localparam int EV_GUARD = 1;
  localparam int EV_SYNC = 2;
  localparam int EV_BUSOFF = 3;
  localparam int EV_WARN = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [4:0] IRQ_STAT_RST = 5'h00;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_SINGLE, PAT_DOUBLE, PAT_TRIPLE, PAT_BLINK, PAT_RAPID
  } pattern_type;

  typedef enum logic [1:0] {BOOT_WAIT, BOOT_CHECK, BOOT_OK, BOOT_FAIL} boot_type;
endpackage

//--- pkg/led_pattern_if.sv
`timescale 1ns/1ns
interface led_pattern_if;
  import led_pkg::*;
  pattern_type pattern;
  logic led;
  modport ctl(output pattern, input led);
  modport gen(input pattern, output led);
endinterface

//--- verilog/switch_sync.sv
`timescale 1ns/1ns
module switch_sync #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // raw pins and filtered value
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a switch in mid-turn is only taken once two stages agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncOut <= '0;
    end else if (s2_r == s3_r) begin
      syncOut <= s3_r;
    end
  end
endmodule

//--- verilog/flash_pattern_gen.sv
`timescale 1ns/1ns
module flash_pattern_gen import led_pkg::*; #(
  parameter int PHASE_CYC_P = PHASE_CYC,
  parameter int RAPID_CYC_P = RAPID_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // pattern request and lamp drive
  led_pattern_if.gen pat
);
  function automatic logic [3:0] flashCount(pattern_type p);
    case (p)
      PAT_SINGLE: return 4'h1;
      PAT_DOUBLE: return 4'h2;
      PAT_TRIPLE: return 4'h3;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] frameLen(pattern_type p);
    logic [3:0] n;
    n = flashCount(p);
    if (p == PAT_BLINK) return 4'h2;
    if (n != 4'h0) return {n[2:0], 1'b0} + 4'(GAP_STEPS);
    return 4'h1;
  endfunction

  pattern_type lastPat_r;
  logic [31:0] phaseCnt_r;
  logic [31:0] rapidCnt_r;
  logic [3:0] step_r;
  logic rapidLed_r;
  logic led_r;
  logic led_nxt;
  logic change;
  logic phaseTick;
  logic rapidTick;

  assign change = (pat.pattern != lastPat_r);
  assign phaseTick = (phaseCnt_r == 32'(PHASE_CYC_P - 1));
  assign rapidTick = (rapidCnt_r == 32'(RAPID_CYC_P - 1));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) lastPat_r <= PAT_OFF;
    else lastPat_r <= pat.pattern;
  end

  // a new pattern restarts its frame so the first flash is full length
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phaseCnt_r <= 32'h0;
      step_r <= 4'h0;
    end else if (change) begin
      phaseCnt_r <= 32'h0;
      step_r <= 4'h0;
    end else if (phaseTick) begin
      phaseCnt_r <= 32'h0;
      step_r <= (step_r == frameLen(pat.pattern) - 4'h1) ? 4'h0 : step_r + 4'h1;
    end else begin
      phaseCnt_r <= phaseCnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rapidCnt_r <= 32'h0;
      rapidLed_r <= 1'b0;
    end else if (change || rapidTick) begin
      rapidCnt_r <= 32'h0;
      rapidLed_r <= change ? 1'b1 : ~rapidLed_r;
    end else begin
      rapidCnt_r <= rapidCnt_r + 32'h1;
    end
  end

  always_comb begin
    case (pat.pattern)
      PAT_OFF: led_nxt = 1'b0;
      PAT_ON: led_nxt = 1'b1;
      PAT_BLINK: led_nxt = ~step_r[0];
      PAT_RAPID: led_nxt = rapidLed_r;
      PAT_SINGLE, PAT_DOUBLE, PAT_TRIPLE:
        led_nxt = (step_r < {flashCount(pat.pattern), 1'b0}) && !step_r[0];
      default: led_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) led_r <= 1'b0;
    else led_r <= change ? 1'b0 : led_nxt;
  end

  assign pat.led = led_r;
endmodule

//--- verilog/canopen_status_led_indicator.sv
`timescale 1ns/1ns
module canopen_status_led_indicator import led_pkg::*; #(
  parameter int PHASE_CYC_P = PHASE_CYC,
  parameter int RAPID_CYC_P = RAPID_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // interrupt
  output logic irq,
  // rotary switch pins
  input wire logic [7:0] nodeIdSw,
  input wire logic [3:0] baudSw,
  // node state from the protocol engine
  input wire logic nodeReady,
  input wire logic [1:0] nmtState,
  // can controller
  input wire logic [7:0] txErrCnt,
  input wire logic [7:0] rxErrCnt,
  input wire logic busOff,
  // supervision
  input wire logic guardEvt,
  input wire logic heartbeatEvt,
  input wire logic syncTimeout,
  // i/o expansion modules
  input wire logic moduleRemoved,
  input wire logic moduleChanged,
  // lamps and start-up results
  output logic runLed,
  output logic errLed,
  output logic bootFail,
  output logic initMode,
  output logic [7:0] nodeId,
  output logic [3:0] baudSel
);
  function automatic logic nodeIdOk(logic [7:0] id);
    return (id != NODE_ID_NONE) && (id != NODE_ID_GAP);
  endfunction

  function automatic logic baudOk(logic [3:0] b);
    return (b <= BAUD_RUN_MAX) || (b == BAUD_INIT);
  endfunction

  // one verdict for the state machine and the flag, so they cannot disagree
  function automatic logic switchesOk(logic [11:0] sw);
    return nodeIdOk(sw[7:0]) && baudOk(sw[11:8]);
  endfunction

  led_pattern_if runIf();
  led_pattern_if errIf();

  logic [11:0] swSync;
  boot_type bootSt_r;
  logic [3:0] bootCnt_r;
  logic bootOk;
  logic moduleErr_r;
  logic guardErr_r;
  logic syncPrev_r;
  logic busOffPrev_r;
  logic warnPrev_r;
  logic warnLvl;
  logic [EV_W-1:0] evt;
  logic [EV_W-1:0] irqStat_r;
  logic [EV_W-1:0] irqMask_r;
  logic [EV_W-1:0] statClr;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic addrAcc;
  logic hit;
  logic [31:0] rdData;
  logic [31:0] hrdata_r;
  logic modClr;
  logic guardClr;

  //////////////////////////////////////////////////////////////////////////
  // switch capture at start-up

  switch_sync #(.W(12)) swSyncInst (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({baudSw, nodeIdSw}),
    .syncOut(swSync)
  );

  // switches are read once; turning them later has no effect until reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bootSt_r <= BOOT_WAIT;
      bootCnt_r <= 4'h0;
    end else begin
      case (bootSt_r)
        BOOT_WAIT: begin
          bootCnt_r <= bootCnt_r + 4'h1;
          if (bootCnt_r == BOOT_WAIT_CYC - 4'h1) bootSt_r <= BOOT_CHECK;
        end
        BOOT_CHECK: begin
          if (switchesOk(swSync)) bootSt_r <= BOOT_OK;
          else bootSt_r <= BOOT_FAIL;
        end
        BOOT_OK: bootSt_r <= BOOT_OK;
        // a refused start-up is left only through reset
        BOOT_FAIL: bootSt_r <= BOOT_FAIL;
        default: bootSt_r <= BOOT_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nodeId <= 8'h00;
      baudSel <= 4'h0;
      bootFail <= 1'b0;
      initMode <= 1'b0;
    end else if (bootSt_r == BOOT_CHECK) begin
      nodeId <= swSync[7:0];
      baudSel <= swSync[11:8];
      bootFail <= !switchesOk(swSync);
      initMode <= (swSync[11:8] == BAUD_INIT);
    end
  end

  // both lamps and the module-fault latch wait for a good start-up
  assign bootOk = (bootSt_r == BOOT_OK);

  //////////////////////////////////////////////////////////////////////////
  // sticky error conditions and events

  // either counter at the warning level is enough
  assign warnLvl = (txErrCnt >= WARN_LEVEL) || (rxErrCnt >= WARN_LEVEL);

  // sync, bus-off and warning levels become one-cycle events so a held one raises its interrupt once; module and guard inputs pass as levels
  assign evt[EV_MODULE] = bootOk && (moduleRemoved || moduleChanged);
  assign evt[EV_GUARD] = guardEvt || heartbeatEvt;
  assign evt[EV_SYNC] = syncTimeout && !syncPrev_r;
  assign evt[EV_BUSOFF] = busOff && !busOffPrev_r;
  assign evt[EV_WARN] = warnLvl && !warnPrev_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncPrev_r <= 1'b0;
      busOffPrev_r <= 1'b0;
      warnPrev_r <= 1'b0;
    end else begin
      syncPrev_r <= syncTimeout;
      busOffPrev_r <= busOff;
      warnPrev_r <= warnLvl;
    end
  end

  // module fault holds until the tool clears it; a new fault wins the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) moduleErr_r <= 1'b0;
    else moduleErr_r <= (moduleErr_r && !modClr) || evt[EV_MODULE];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) guardErr_r <= 1'b0;
    else guardErr_r <= (guardErr_r && !guardClr) || evt[EV_GUARD];
  end

  //////////////////////////////////////////////////////////////////////////
  // pattern selection

  // a module fault outranks the node state so a pulled module is seen
  always_comb begin
    if (!bootOk || !nodeReady) begin
      runIf.pattern = PAT_OFF;
    end else if (moduleErr_r) begin
      runIf.pattern = PAT_RAPID;
    end else begin
      case (nmtState)
        NMT_STOPPED: runIf.pattern = PAT_SINGLE;
        NMT_PREOP: runIf.pattern = PAT_BLINK;
        NMT_OPER: runIf.pattern = PAT_ON;
        default: runIf.pattern = PAT_OFF;
      endcase
    end
  end

  // the chain order is the severity order
  // a node that never booted shows no error pattern either
  always_comb begin
    if (!bootOk) begin
      errIf.pattern = PAT_OFF;
    end else if (busOff) begin
      errIf.pattern = PAT_ON;
    end else if (syncTimeout) begin
      errIf.pattern = PAT_TRIPLE;
    end else if (guardErr_r) begin
      errIf.pattern = PAT_DOUBLE;
    end else if (warnLvl) begin
      errIf.pattern = PAT_SINGLE;
    end else begin
      errIf.pattern = PAT_OFF;
    end
  end

  flash_pattern_gen #(.PHASE_CYC_P(PHASE_CYC_P), .RAPID_CYC_P(RAPID_CYC_P)) runGen (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pat(runIf)
  );

  flash_pattern_gen #(.PHASE_CYC_P(PHASE_CYC_P), .RAPID_CYC_P(RAPID_CYC_P)) errGen (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pat(errIf)
  );

  assign runLed = runIf.led;
  assign errLed = errIf.led;

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  assign addrAcc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  // only the low 256 bytes decode; anything above reads as zero
  assign hit = (haddr[31:8] == 24'h0);

  // a write lands in its data phase, when hwdata stands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= addrAcc && hwrite && hit;
      if (addrAcc && hwrite) wrAddr_r <= haddr[7:0];
    end
  end

  // control bits act for one cycle and are not stored
  assign modClr = wrPend_r && (wrAddr_r == ADDR_CTRL) && hwdata[CTRL_MODCLR_BIT];
  assign guardClr = wrPend_r && (wrAddr_r == ADDR_CTRL) && hwdata[CTRL_GUARDCLR_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) irqMask_r <= IRQ_MASK_RST;
    else if (wrPend_r && (wrAddr_r == ADDR_IRQ_MASK)) irqMask_r <= hwdata[EV_W-1:0];
  end

  // read data is sampled in the address phase, so a read that overlaps the
  // data phase of a write sees the value from before that write
  always_comb begin
    rdData = 32'h0;
    if (hit) begin
      case (haddr[7:0])
        ADDR_STATUS: rdData = {24'h0, 1'b0, bootOk, 3'(errIf.pattern), 3'(runIf.pattern)};
        ADDR_SWITCH: rdData = {14'h0, initMode, bootFail, 4'h0, baudSel, nodeId};
        ADDR_IRQ_STAT: rdData = {27'h0, irqStat_r};
        ADDR_IRQ_MASK: rdData = {27'h0, irqMask_r};
        ADDR_CTRL: rdData = {30'h0, guardErr_r, moduleErr_r};
        default: rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hrdata_r <= 32'h0;
    else if (addrAcc && !hwrite) hrdata_r <= rdData;
  end

  assign hrdata = hrdata_r;
  // every transfer completes at once, so the slave never stalls the bus
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by reading it; a same-cycle event survives

  assign statClr = (addrAcc && !hwrite && hit && (haddr[7:0] == ADDR_IRQ_STAT)) ?
                   {EV_W{1'b1}} : {EV_W{1'b0}};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) irqStat_r <= IRQ_STAT_RST;
    else irqStat_r <= (irqStat_r & ~statClr) | evt;
  end

  // level output: stays high until software reads the status or masks the event
  assign irq = |(irqStat_r & irqMask_r);
endmodule

//--- bench/led_status_sva.sv
`timescale 1ns/1ns
module led_status_sva import led_pkg::*; #(
  parameter int PHASE_CYC_P = PHASE_CYC,
  parameter int RAPID_CYC_P = RAPID_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // node and fault inputs
  input wire logic nodeReady,
  input wire logic busOff,
  input wire logic syncTimeout,
  // lamps and start-up results
  input wire logic runLed,
  input wire logic errLed,
  input wire logic bootFail,
  input wire logic initMode,
  input wire logic [7:0] nodeId,
  input wire logic [3:0] baudSel
);
  logic [3:0] upCnt_r;
  logic [15:0] errOn_r, errOff_r, steady_r;
  logic syncPrev_r, boPrev_r;
  logic booted;
  // switch outputs settle some edges after the start-up capture
  assign booted = upCnt_r > 4'hB;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_r <= 4'h0;
      errOn_r <= 16'h0000;
      errOff_r <= 16'h0000;
      steady_r <= 16'h0000;
      syncPrev_r <= 1'h0;
      boPrev_r <= 1'h0;
    end else begin
      upCnt_r <= (upCnt_r == 4'hF) ? upCnt_r : upCnt_r + 4'h1;
      errOn_r <= errLed ? errOn_r + 16'h0001 : 16'h0000;
      errOff_r <= errLed ? 16'h0000 : errOff_r + 16'h0001;
      // run lengths only count when the fault inputs stood still
      steady_r <= (syncTimeout != syncPrev_r || busOff != boPrev_r) ? 16'h0000 :
        steady_r + 16'h0001;
      syncPrev_r <= syncTimeout;
      boPrev_r <= busOff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence busoff_held;
    busOff [*8];
  endsequence
  sequence triple_settled;
    syncTimeout && !busOff && steady_r > 14 * PHASE_CYC_P;
  endsequence
  run_dark_a: assert property (!nodeReady [*5] |-> !runLed)
    else $error("run lamp lit while node not ready");
  busoff_on_a: assert property (busoff_held ##0 booted && !bootFail |-> errLed)
    else $error("error lamp dark during bus-off");
  lamps_dark_a: assert property (bootFail |-> !runLed && !errLed)
    else $error("lamp lit after refused start-up");
  init_sel_a: assert property (booted |-> initMode == (baudSel == BAUD_INIT))
    else $error("initial mode does not follow baud selector");
  boot_check_a: assert property (booted |-> bootFail == (nodeId == NODE_ID_NONE ||
    nodeId == NODE_ID_GAP || baudSel == 4'h8 || baudSel > BAUD_INIT))
    else $error("start-up verdict wrong for switch values");
  sw_hold_a: assert property (booted && $past(booted) |-> $stable(nodeId) && $stable(baudSel))
    else $error("switch capture changed after start-up");
  flash_on_a: assert property ($fell(errLed) ##0 triple_settled |-> errOn_r == PHASE_CYC_P)
    else $error("flash on phase has wrong length");
  flash_gap_a: assert property ($rose(errLed) ##0 triple_settled |->
    errOff_r == PHASE_CYC_P || errOff_r == 6 * PHASE_CYC_P)
    else $error("flash dark phase has wrong length");
endmodule
bind canopen_status_led_indicator led_status_sva #(
  .PHASE_CYC_P(PHASE_CYC_P),
  .RAPID_CYC_P(RAPID_CYC_P)
) chk (.clk_sys, .rst_b, .nodeReady, .busOff, .syncTimeout, .runLed, .errLed,
  .bootFail, .initMode, .nodeId, .baudSel);

//--- bench/lamp_viewer.sv
`timescale 1ns/1ns
module lamp_viewer import led_pkg::*; #(
  parameter int P = 20,
  parameter int R = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // lamp as the operator sees it
  input wire logic lamp,
  output pattern_type shown
);
  int onRun, offRun, lastOn, flashes, grp, gapAge;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      onRun <= 0;
      offRun <= 0;
      lastOn <= 0;
      flashes <= 0;
      grp <= 0;
      gapAge <= 0;
    end else if (lamp) begin
      // a long dark spell closes a flash group
      if (offRun >= 3 * P) begin
        grp <= flashes;
        flashes <= 1;
        gapAge <= 0;
      end else begin
        flashes <= (offRun > 0) ? flashes + 1 : flashes;
        gapAge <= gapAge + 1;
      end
      onRun <= onRun + 1;
      offRun <= 0;
    end else begin
      if (onRun > 0)
        lastOn <= onRun;
      onRun <= 0;
      offRun <= offRun + 1;
      gapAge <= gapAge + 1;
    end
  end
  always_comb begin
    if (lamp && onRun >= 2 * P)
      shown = PAT_ON;
    else if (!lamp && offRun >= 8 * P)
      shown = PAT_OFF;
    else if (lastOn == R)
      shown = PAT_RAPID;
    else if (gapAge > 12 * P)
      shown = PAT_BLINK;
    else
      shown = pattern_type'(3'(grp + 1));
  end
endmodule

//--- bench/canopen_status_led_indicator_tb_top.sv
`timescale 1ns/1ns
module canopen_status_led_indicator_tb_top import led_pkg::*;;
  localparam int P = 20;
  localparam int R = 5;
  typedef struct packed {
    logic [1:0] nmt;
    logic bo, sy;
    logic [7:0] tx, rx;
    logic [1:0] ev;
    logic clr;
    pattern_type er, ee;
  } row_type;
  logic clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp, irq, nodeReady, busOff;
  logic syncTimeout, guardEvt, heartbeatEvt, moduleRemoved, moduleChanged;
  logic runLed, errLed, bootFail, initMode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, nmtState;
  logic [2:0] hsize;
  logic [7:0] nodeIdSw, txErrCnt, rxErrCnt, nodeId;
  logic [3:0] baudSw, baudSel;
  pattern_type runSeen, errSeen;
  int numErrors = 0;
  int checkCount = 0;
  // {id, baud, refused, initial}
  logic [13:0] boots [6] = '{14'h2065, 14'h000A, 14'h200A, 14'h0422, 14'h042A, 14'h014C};
  row_type rows [10] = '{
    '{NMT_INIT, 1'h0, 1'h0, 8'h00, 8'h00, 2'h0, 1'h0, PAT_OFF, PAT_OFF},
    '{NMT_STOPPED, 1'h0, 1'h0, 8'h5F, 8'h5F, 2'h0, 1'h0, PAT_SINGLE, PAT_OFF},
    '{NMT_PREOP, 1'h0, 1'h0, 8'h60, 8'h00, 2'h0, 1'h0, PAT_BLINK, PAT_SINGLE},
    '{NMT_OPER, 1'h0, 1'h0, 8'h00, 8'h60, 2'h0, 1'h0, PAT_ON, PAT_SINGLE},
    '{NMT_OPER, 1'h0, 1'h1, 8'h60, 8'h00, 2'h0, 1'h0, PAT_ON, PAT_TRIPLE},
    '{NMT_OPER, 1'h1, 1'h1, 8'h00, 8'h00, 2'h0, 1'h0, PAT_ON, PAT_ON},
    '{NMT_OPER, 1'h0, 1'h0, 8'h00, 8'h00, 2'h2, 1'h0, PAT_ON, PAT_DOUBLE},
    '{NMT_OPER, 1'h0, 1'h1, 8'h00, 8'h00, 2'h0, 1'h0, PAT_ON, PAT_TRIPLE},
    '{NMT_OPER, 1'h0, 1'h0, 8'h00, 8'h00, 2'h1, 1'h1, PAT_ON, PAT_DOUBLE},
    '{NMT_OPER, 1'h0, 1'h0, 8'h00, 8'h00, 2'h0, 1'h1, PAT_ON, PAT_OFF}};
  assign hready = hreadyout;
  canopen_status_led_indicator #(.PHASE_CYC_P(P), .RAPID_CYC_P(R)) uut (.clk_sys, .rst_b,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .irq, .nodeIdSw, .baudSw, .nodeReady, .nmtState, .txErrCnt, .rxErrCnt, .busOff,
    .guardEvt, .heartbeatEvt, .syncTimeout, .moduleRemoved, .moduleChanged, .runLed,
    .errLed, .bootFail, .initMode, .nodeId, .baudSel);
  lamp_viewer #(.P(P), .R(R)) runView (.clk_sys, .rst_b, .lamp(runLed), .shown(runSeen));
  lamp_viewer #(.P(P), .R(R)) errView (.clk_sys, .rst_b, .lamp(errLed), .shown(errSeen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  // {removed, changed, guard, heartbeat}
  task automatic pulse(input logic [3:0] m);
    {moduleRemoved, moduleChanged, guardEvt, heartbeatEvt} <= m;
    @(posedge clk_sys);
    {moduleRemoved, moduleChanged, guardEvt, heartbeatEvt} <= 4'h0;
  endtask
  // long enough for a full group and the viewer's blink spell
  task automatic see(input pattern_type er, input pattern_type ee);
    repeat (30 * P) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("run lamp", 32'(er), 32'(runSeen));
    chk("error lamp", 32'(ee), 32'(errSeen));
    ahb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", {25'h0, 1'h1, ee, er}, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    numErrors++;
    close_out();
  end
  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata, nmtState} = '0;
    {busOff, syncTimeout, moduleRemoved, moduleChanged, guardEvt, heartbeatEvt} = '0;
    {txErrCnt, rxErrCnt} = '0;
    hsize = HSIZE_WORD;
    nodeReady = 1'h1;
    nodeIdSw = 8'h05;
    baudSw = 4'h3;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (12) @(posedge clk_sys);
    ahb(1'h0, ADDR_SWITCH, 32'h0);
    chk("switch reg", 32'h0000_0305, rd);
    ahb(1'h0, ADDR_IRQ_MASK, 32'h0);
    chk("mask reset", {27'h0, IRQ_MASK_RST}, rd);
    ahb(1'h0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      if (rows[i].clr)
        ahb(1'h1, ADDR_CTRL, 32'h1 << CTRL_GUARDCLR_BIT);
      {nmtState, busOff, syncTimeout, txErrCnt, rxErrCnt} <= rows[i][28:9];
      pulse({2'h0, rows[i].ev});
      see(rows[i].er, rows[i].ee);
    end
    pulse(4'h8);
    nmtState <= NMT_PREOP;
    see(PAT_RAPID, PAT_OFF);
    ahb(1'h0, ADDR_CTRL, 32'h0);
    chk("fault latch", 32'h1, rd);
    ahb(1'h1, ADDR_CTRL, 32'h1 << CTRL_MODCLR_BIT);
    see(PAT_BLINK, PAT_OFF);
    pulse(4'h4);
    see(PAT_RAPID, PAT_OFF);
    ahb(1'h1, ADDR_CTRL, 32'h1 << CTRL_MODCLR_BIT);
    nodeReady <= 1'h0;
    see(PAT_OFF, PAT_OFF);
    nodeReady <= 1'h1;
    // a byte-wide write must leave the mask alone
    hsize <= 3'h0;
    ahb(1'h1, ADDR_IRQ_MASK, 32'h1F);
    hsize <= HSIZE_WORD;
    ahb(1'h0, ADDR_IRQ_MASK, 32'h0);
    chk("byte write", 32'h0, rd);
    // interrupt: only the sync event is let through
    ahb(1'h1, ADDR_IRQ_MASK, 32'h1 << EV_SYNC);
    ahb(1'h0, ADDR_IRQ_STAT, 32'h0);
    pulse(4'h2);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    syncTimeout <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk("irq status", (32'h1 << EV_GUARD) | (32'h1 << EV_SYNC), rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    foreach (boots[i]) begin
      {nodeIdSw, baudSw} <= boots[i][13:2];
      rst_b <= 1'h0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'h1;
      repeat (20) @(posedge clk_sys);
      chk("captured", {20'h0, boots[i][13:2]}, {20'h0, nodeId, baudSel});
      chk("boot flags", {30'h0, boots[i][1:0]}, {30'h0, bootFail, initMode});
      chk("run after boot", {31'h0, !boots[i][1]}, {31'h0, runLed});
      chk("err after boot", {31'h0, !boots[i][1]}, {31'h0, errLed});
    end
    close_out();
  end
endmodule
